// File: hdl/pgm_config.sv
// Power-good monitor configuration bank with Wishbone slave and interrupt.
`timescale 1ns/1ps
`default_nettype none
module pgm_config
	import pgm_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [5:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic otp_load,
	input wire logic [7:0] otp_enable,
	input wire logic [7:0] otp_level_a,
	input wire logic [7:0] otp_level_b,
	input wire logic monitor_active,
	input wire pgm_cmp_t rail_cmp,
	output pgm_enable_t enable_cfg,
	output pgm_level_a_t level_a_cfg,
	output pgm_level_b_t level_b_cfg,
	output logic input_a_low_impedance,
	output logic input_b_low_impedance,
	output logic power_good_out_first,
	output logic power_good_out_second,
	output logic irq
);
	logic [7:0] enable_r;
	logic [7:0] level_a_r;
	logic [7:0] level_b_r;
	logic [7:0] irq_status_r;
	logic [7:0] irq_mask_r;
	logic [pgm_rails-1:0] fault_r;
	logic [31:0] rd_nxt;
	logic hit;
	logic wr_stb;
	logic [pgm_rails-1:0] rail_en;
	logic [pgm_rails-1:0] uv_seen;
	logic [pgm_rails-1:0] ov_seen;
	logic [pgm_rails-1:0] fault_nxt;
	logic cfg_changed;
	logic [7:0] irq_set;

	// Merges a write into an 8-bit register on lane 0, keeping only implemented bits.
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
		merge = wb_sel_i[0] ? (wb_dat_i[7:0] & mask) : old;
	endfunction : merge

	always_comb begin
		hit = 1'b1;
		rd_nxt = 32'h0000_0000;
		case (wb_adr_i)
			pgm_off_enable: rd_nxt[7:0] = enable_r;
			pgm_off_level_a: rd_nxt[7:0] = level_a_r;
			pgm_off_level_b: rd_nxt[7:0] = level_b_r;
			pgm_off_irq_status: rd_nxt[7:0] = irq_status_r;
			pgm_off_irq_mask: rd_nxt[7:0] = irq_mask_r;
			pgm_off_rail_status: rd_nxt[pgm_rails-1:0] = fault_r;
			default: hit = 1'b0;
		endcase
	end

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && hit;

	// One-cycle answer; the strobe is ignored only in the answer cycle, so a strobe still held is answered again.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit;
			wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit;
			wb_dat_o <= rd_nxt;
		end
	end

	// Registers reset to zero and take their defaults from the OTP load strobe.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enable_r <= pgm_reset_value;
			level_a_r <= pgm_reset_value;
			level_b_r <= pgm_reset_value;
		end else if (otp_load) begin
			enable_r <= otp_enable & pgm_enable_mask;
			level_a_r <= otp_level_a & pgm_level_a_mask;
			level_b_r <= otp_level_b & pgm_level_b_mask;
		end else if (wr_stb) begin
			if (wb_adr_i == pgm_off_enable) begin
				enable_r <= merge(enable_r, pgm_enable_mask);
			end
			if (wb_adr_i == pgm_off_level_a) begin
				level_a_r <= merge(level_a_r, pgm_level_a_mask);
			end
			if (wb_adr_i == pgm_off_level_b) begin
				level_b_r <= merge(level_b_r, pgm_level_b_mask);
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enable_cfg <= '0;
			level_a_cfg <= '0;
			level_b_cfg <= '0;
			input_a_low_impedance <= 1'b0;
			input_b_low_impedance <= 1'b0;
		end else begin
			enable_cfg <= pgm_enable_t'(enable_r[6:0]);
			level_a_cfg <= pgm_level_a_t'(level_a_r[4:0]);
			level_b_cfg <= pgm_level_b_t'(level_b_r);
			input_a_low_impedance <= level_a_r[2:0] != pgm_nominal_hiz;
			input_b_low_impedance <= level_b_r[2:0] != pgm_nominal_hiz;
		end
	end

	assign rail_en = enable_r[pgm_rails-1:0] & {pgm_rails{monitor_active}};
	assign uv_seen = rail_cmp.under & rail_en;
	// Overvoltage only counts in windowed mode.
	assign ov_seen = rail_cmp.over & rail_en & {pgm_rails{enable_r[pgm_bit_window]}};
	assign fault_nxt = uv_seen | ov_seen;
	assign cfg_changed = wr_stb && monitor_active && (wb_adr_i == pgm_off_enable) && wb_sel_i[0]
		&& ((wb_dat_i[6:0] & pgm_enable_mask[6:0]) != enable_r[6:0]);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fault_r <= '0;
			power_good_out_first <= 1'b0;
			power_good_out_second <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
			power_good_out_first <= monitor_active && fault_nxt == '0;
			power_good_out_second <= monitor_active && fault_nxt == '0;
		end
	end

	always_comb begin
		irq_set = 8'h00;
		irq_set[pgm_irq_undervolt] = |uv_seen;
		irq_set[pgm_irq_overvolt] = |ov_seen;
		irq_set[pgm_irq_cfg_change] = cfg_changed;
	end

	// A set in the same cycle as a write-one clear wins.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq_status_r <= pgm_reset_value;
			irq_mask_r <= pgm_reset_value;
			irq <= 1'b0;
		end else begin
			if (wr_stb && wb_adr_i == pgm_off_irq_status && wb_sel_i[0]) begin
				irq_status_r <= (irq_status_r & ~wb_dat_i[7:0]) | irq_set;
			end else begin
				irq_status_r <= irq_status_r | irq_set;
			end
			if (wr_stb && wb_adr_i == pgm_off_irq_mask) begin
				irq_mask_r <= merge(irq_mask_r, pgm_irq_mask_bits);
			end
			irq <= |(irq_status_r & irq_mask_r);
		end
	end
endmodule : pgm_config
`default_nettype wire

// File: hdl/pgm_pkg.sv
// Constants, field layouts and carrier types of the power-good monitor configuration bank.
// Summary of operation
// - Bit 6 picks undervoltage-only or windowed checking
// - Bits 5..0 enable each supervised rail
// - Changing method or enables may raise interrupt
// - Field defaults come from OTP memory
// - Registers at 13h, 14h, 15h, reset zero
// - Input A tolerance code in level1 bits 4-3
// - Input A nominal code in level1 bits 2-0
// - Nominal code zero leaves input high-impedance
// - Input B tolerance code in level2 bits 4-3
// - Input B nominal code in level2 bits 2-0
// - Analog tolerance code in level2 bits 7-6
// - Level2 bit 5 picks 3.3 or 5.0 volts
package pgm_pkg;
	localparam int unsigned pgm_rails = 6;
	localparam logic [5:0] pgm_off_enable = 6'h13;
	localparam logic [5:0] pgm_off_level_a = 6'h14;
	localparam logic [5:0] pgm_off_level_b = 6'h15;
	localparam logic [5:0] pgm_off_irq_status = 6'h18;
	localparam logic [5:0] pgm_off_irq_mask = 6'h19;
	localparam logic [5:0] pgm_off_rail_status = 6'h1a;
	localparam logic [7:0] pgm_reset_value = 8'h00;
	localparam int unsigned pgm_bit_window = 6;
	localparam logic [7:0] pgm_enable_mask = 8'h7f;
	localparam logic [7:0] pgm_level_a_mask = 8'h1f;
	localparam logic [7:0] pgm_level_b_mask = 8'hff;
	localparam logic [2:0] pgm_nominal_hiz = 3'h0;
	// Interrupt status bits.
	localparam int unsigned pgm_irq_undervolt = 0;
	localparam int unsigned pgm_irq_overvolt = 1;
	localparam int unsigned pgm_irq_cfg_change = 2;
	localparam logic [7:0] pgm_irq_mask_bits = 8'h07;

	typedef struct packed {
		logic windowed_check_select;
		logic analog_supply_check_enable;
		logic input_b_check_enable;
		logic input_a_check_enable;
		logic boost_check_enable;
		logic second_buck_check_enable;
		logic first_buck_check_enable;
	} pgm_enable_t;

	typedef struct packed {
		logic [1:0] analog_supply_tolerance;
		logic analog_supply_nominal;
		logic [1:0] input_b_tolerance;
		logic [2:0] input_b_nominal;
	} pgm_level_b_t;

	typedef struct packed {
		logic [1:0] input_a_tolerance;
		logic [2:0] input_a_nominal;
	} pgm_level_a_t;

	// Per-rail comparator results, bit order as the enable bits.
	typedef struct packed {
		logic [pgm_rails-1:0] under;
		logic [pgm_rails-1:0] over;
	} pgm_cmp_t;
endpackage : pgm_pkg

// File: sim/pgm_config_sva.sv
// Checker of bus answers, reset state and power-good evaluation.
`timescale 1ns/1ps
`default_nettype none
module pgm_config_sva
	import pgm_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [5:0] wb_adr_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic monitor_active,
	input wire pgm_cmp_t rail_cmp,
	input wire pgm_enable_t enable_cfg,
	input wire pgm_level_a_t level_a_cfg,
	input wire logic input_a_low_impedance,
	input wire logic power_good_out_first,
	input wire logic power_good_out_second
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
	wire logic [6:0] ec = enable_cfg;
	wire logic mapped = wb_adr_i inside {6'h13, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1a};
	one_answer_a: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no answer");
	unmapped_err_a: assert property (req && !mapped |=> wb_err_o) else $error("no err");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
	reset_zero_a: assert property ($rose(rstn) |-> ec == 7'h00 && level_a_cfg == 5'h00)
		else $error("reset value");
	low_imp_a: assert property (input_a_low_impedance == (level_a_cfg[2:0] != 3'h0))
		else $error("impedance");
	pg_eval_a: assert property (power_good_out_first == ($past(monitor_active) &&
		!(|(($past(rail_cmp.under) | $past(rail_cmp.over) & {6{ec[6]}}) & ec[5:0]))))
		else $error("pg value");
	pg_pair_a: assert property (power_good_out_first == power_good_out_second)
		else $error("pg pair");
	cover property (wb_ack_o);
	cover property (wb_err_o);
	cover property (monitor_active && $fell(power_good_out_first));
endmodule : pgm_config_sva
bind pgm_config pgm_config_sva chk (.*);
`default_nettype wire

// File: sim/pgm_config_tb.sv
// Self-checking bench of the power-good monitor configuration bank.
`timescale 1ns/1ps
`default_nettype none
module pgm_config_tb import pgm_pkg::*;;
	logic clock = 1'b0, rstn = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, ld = 1'b0, act = 1'b0, e;
	logic [5:0] adr = 6'h00;
	logic [7:0] dat = 8'h00;
	pgm_cmp_t cmp = '0;
	logic [31:0] q;
	int err_count = 0, tests_run = 0;
	wire logic [31:0] dat_o;
	wire logic ack, err, ia, ib, pg0, pg1, irq;
	wire pgm_enable_t ec;
	wire pgm_level_a_t la;
	wire pgm_level_b_t lb;
	always #5 clock = ~clock;
	pgm_config dut (.clock(clock), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i({24'h000000, dat}),
		.wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .wb_err_o(err), .otp_load(ld), .otp_enable(8'hc1), .otp_level_a(8'he5),
		.otp_level_b(8'h5a), .monitor_active(act), .rail_cmp(cmp), .enable_cfg(ec),
		.level_a_cfg(la), .level_b_cfg(lb), .input_a_low_impedance(ia),
		.input_b_low_impedance(ib), .power_good_out_first(pg0), .power_good_out_second(pg1),
		.irq(irq));
	task chk(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do @(posedge clock); while (ack !== 1'b1 && err !== 1'b1);
		q = dat_o;
		e = err;
		{cyc, stb} <= 2'b00;
	endtask : acc
	task rd(input logic [5:0] a, input logic [31:0] x);
		acc(1'b0, a, 8'h00);
		chk(q, x);
	endtask : rd
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		rd(6'h13, 32'h0);
		rd(6'h14, 32'h0);
		rd(6'h15, 32'h0);
		acc(1'b1, 6'h13, 8'hff);
		rd(6'h13, 32'h7f);
		acc(1'b1, 6'h14, 8'hff);
		rd(6'h14, 32'h1f);
		acc(1'b1, 6'h15, 8'hff);
		rd(6'h15, 32'hff);
		chk({ia, ib, lb}, 10'h3ff);
		acc(1'b1, 6'h14, 8'h18);
		rd(6'h14, 32'h18);
		chk(ia, 1'b0);
		acc(1'b0, 6'h20, 8'h00);
		chk(e, 1'b1);
		$display("register test done");
		@(posedge clock) ld <= 1'b1;
		@(posedge clock) ld <= 1'b0;
		rd(6'h13, 32'h41);
		rd(6'h14, 32'h05);
		rd(6'h15, 32'h5a);
		$display("default load test done");
		@(posedge clock) act <= 1'b1;
		acc(1'b1, 6'h19, 8'h04);
		acc(1'b1, 6'h13, 8'h01);
		rd(6'h18, 32'h4);
		chk(irq, 1'b1);
		acc(1'b1, 6'h18, 8'h04);
		rd(6'h18, 32'h0);
		acc(1'b1, 6'h19, 8'h00);
		acc(1'b1, 6'h13, 8'h03);
		rd(6'h18, 32'h4);
		chk(irq, 1'b0);
		$display("interrupt test done");
		@(posedge clock) cmp <= {6'h04, 6'h00};
		repeat (3) @(posedge clock);
		chk({pg0, pg1}, 2'b11);
		rd(6'h18, 32'h04);
		cmp <= {6'h01, 6'h00};
		repeat (3) @(posedge clock);
		chk({pg0, pg1}, 2'b00);
		rd(6'h1a, 32'h01);
		cmp <= {6'h00, 6'h01};
		repeat (3) @(posedge clock);
		chk(pg0, 1'b1);
		acc(1'b1, 6'h13, 8'h43);
		repeat (3) @(posedge clock);
		chk(pg0, 1'b0);
		rd(6'h18, 32'h07);
		acc(1'b1, 6'h18, 8'h07);
		rd(6'h18, 32'h02);
		$display("power-good test done");
		print_verdict;
	end
	initial begin
		repeat (3000) @(posedge clock);
		err_count++;
		print_verdict;
	end
endmodule : pgm_config_tb
`default_nettype wire
